// ==== cbd_pkg.sv ====
// constants shared by the converter board command decoder
`default_nettype none
package cbd_pkg;

  // ==========================================================================
  // processor i/o command numbers
  localparam logic [2:0] CBD_CMD_SELECT   = 3'h1;
  localparam logic [2:0] CBD_CMD_DAC1     = 3'h3;
  localparam logic [2:0] CBD_CMD_DAC2     = 3'h4;
  localparam logic [2:0] CBD_CMD_ADC_GO   = 3'h5;
  localparam logic [2:0] CBD_CMD_ADC_READ = 3'h3;
  localparam logic [7:0] CBD_SELECT_DEF   = 8'h30;

  // ==========================================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] CBD_OFS_LINKS  = 8'h00;
  localparam logic [7:0] CBD_OFS_STATUS = 8'h04;
  localparam logic [7:0] CBD_OFS_DAC    = 8'h08;
  localparam logic [7:0] CBD_OFS_RESULT = 8'h0C;

  // ==========================================================================
  // link register fields
  localparam int CBD_LNK_DAC1_BIP = 0;
  localparam int CBD_LNK_DAC2_BIP = 1;
  localparam int CBD_LNK_ADC_BIP  = 2;
  localparam int CBD_LNK_DIFF     = 3;
  localparam logic [3:0] CBD_LNK_BIP_MASK = 4'h7;
  // bipolar board: offset binary everywhere, differential inputs
  localparam logic [3:0] CBD_LNK_RST_BIP  = 4'hF;
  // unipolar-only board: straight binary, differential inputs
  localparam logic [3:0] CBD_LNK_RST_UNI  = 4'h8;

  // ==========================================================================
  // status register fields
  localparam int CBD_ST_SELECTED = 0;
  localparam int CBD_ST_SRQ      = 1;
  localparam int CBD_ST_BUSY     = 2;
  localparam int CBD_ST_CHAN_LSB = 4;

  // ==========================================================================
  // reset values and misc
  localparam logic [7:0]  CBD_DAC_RST    = 8'h00;
  localparam logic [7:0]  CBD_RESULT_RST = 8'h00;
  localparam logic [3:0]  CBD_CHAN_RST   = 4'h0;
  localparam logic [31:0] CBD_RDATA_RST  = 32'h0000_0000;
  localparam logic [1:0]  CBD_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    CBD_ADC_IDLE  = 2'b00,
    CBD_ADC_START = 2'b01,
    CBD_ADC_WAIT  = 2'b10
  } cbd_adc_e;

endpackage : cbd_pkg
`default_nettype wire

// ==== cbd_sync.sv ====
// three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ns
`default_nettype none
module cbd_sync
  import cbd_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } cbd_sync_s;

  cbd_sync_s st_r;
  cbd_sync_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // s1 feeds s2 only; a bit changes once the later two agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.lvl;

endmodule : cbd_sync
`default_nettype wire

// ==== cbd_top.sv ====
// converter board command decoder: select, d/a latches, a/d control
//
// Function
// - while selected, output command 3 latches the data byte into d/a channel 1 and starts it.
// - while selected, output command 4 latches the data byte into d/a channel 2 and starts it.
// - each d/a latch holds its byte on the ladder until that channel is written again.
// - in unipolar mode a d/a code is straight binary, zero to full scale minus one step.
// - in bipolar mode a d/a code is offset binary, 1000 0000 being zero and all zeros minus full scale.
// - each d/a channel's coding comes from its own link; the unipolar-only board forces straight binary.
// - the bipolar board resets all channels to offset binary, the unipolar board to straight binary.
// - output command 1 with the board's select code selects it, and converter commands are ignored otherwise.
// - output command 5 takes the byte as a/d channel, clears the service request and starts a conversion.
// - conversion complete is shown on the processor flag line, which the processor polls before reading.
// - input command 3 drives the 8-bit a/d result onto the data bus and clears the service request.
// - the a/d multiplexer runs as sixteen single-ended channels or eight differential pairs by a link.
// - the a/d result is straight binary when unipolar and offset binary, 1000 0000 at zero, when bipolar.
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module cbd_top
  import cbd_pkg::*;
#(
  parameter bit         P_BIPOLAR_CAPABLE = 1'b1,
  parameter logic [7:0] P_SELECT_CODE     = CBD_SELECT_DEF
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // processor i/o bus, same clock
  input  wire logic        i_bus_clear_n,
  input  wire logic [2:0]  i_io_cmd,
  input  wire logic        i_io_dir_in,
  input  wire logic        i_io_strobe,
  input  wire logic [7:0]  i_io_data,
  output logic      [7:0]  o_io_data,
  output logic             o_io_data_oe,
  output logic             o_conversion_done_flag_input,
  // d/a channels
  output logic      [7:0]  o_dac1_code,
  output logic      [7:0]  o_dac2_code,
  output logic             o_dac1_go,
  output logic             o_dac2_go,
  output logic             o_dac1_bipolar,
  output logic             o_dac2_bipolar,
  // a/d converter
  output logic             o_adc_start,
  output logic      [3:0]  o_adc_channel,
  output logic             o_adc_differential,
  output logic             o_adc_bipolar,
  input  wire logic        i_adc_done,
  input  wire logic [7:0]  i_adc_data,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic      [31:0] o_hrdata
);

  // ==========================================================================
  // link defaults per board variant
  localparam logic [3:0] LNK_RST = P_BIPOLAR_CAPABLE ?
                                   CBD_LNK_RST_BIP : CBD_LNK_RST_UNI;
  // unipolar board also masks the range bits in eff_links

  // ==========================================================================
  // state
  typedef struct packed {
    logic        selected;
    logic [7:0]  dac1;
    logic [7:0]  dac2;
    logic        dac1_go;
    logic        dac2_go;
    logic [3:0]  chan;
    cbd_adc_e    adc_st;
    logic        srq;
    logic [7:0]  result;
    logic        done_prev;
    // software stand-in for the board links
    logic [3:0]  links;
    // write address held over into the data phase
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
  } cbd_top_s;

  cbd_top_s st_r;
  cbd_top_s st_nxt;

  localparam cbd_top_s ST_RST = '{
    selected:  1'b0,
    dac1:      CBD_DAC_RST,
    dac2:      CBD_DAC_RST,
    dac1_go:   1'b0,
    dac2_go:   1'b0,
    chan:      CBD_CHAN_RST,
    adc_st:    CBD_ADC_IDLE,
    srq:       1'b0,
    result:    CBD_RESULT_RST,
    done_prev: 1'b0,
    links:     LNK_RST,
    wr_pend:   1'b0,
    wr_addr:   8'h00,
    hrdata:    CBD_RDATA_RST
  };

  // ==========================================================================
  // helpers
  // unipolar-only board has no offset binary path at all
  function automatic logic [3:0] eff_links(input logic [3:0] l);
    logic [3:0] r;
    r = l;
    if (!P_BIPOLAR_CAPABLE) begin
      r = l & ~CBD_LNK_BIP_MASK;
    end
    return r;
  endfunction : eff_links

  function automatic logic is_out(input logic [2:0] cmd,
                                  input logic [2:0] want,
                                  input logic       dir_in,
                                  input logic       strobe);
    return strobe && !dir_in && (cmd == want);
  endfunction : is_out

  // register decode on the low address byte; upper bits are not decoded
  function automatic logic ofs_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
    return a == ofs;
  endfunction : ofs_hit

  // ==========================================================================
  // a/d done synchroniser
  // the converter runs on its own timing, so done is retimed first
  logic adc_done_s;

  cbd_sync #(
    .WIDTH (1)
  ) u_done_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async (i_adc_done),
    .o_level (adc_done_s)
  );

  // ==========================================================================
  // decode of the processor bus
  logic       cmd_sel;
  logic       cmd_dac1;
  logic       cmd_dac2;
  logic       cmd_adc;
  logic       rd_window;
  logic       cmd_rd;
  logic       done_rise;
  logic [3:0] lnk;
  logic [3:0] chan_in;
  logic       ahb_take;
  logic [31:0] rd_word;

  always_comb begin
    lnk      = eff_links(st_r.links);
    cmd_sel  = is_out(i_io_cmd, CBD_CMD_SELECT, i_io_dir_in, i_io_strobe);
    // converter commands count only while selected
    cmd_dac1 = st_r.selected &&
               is_out(i_io_cmd, CBD_CMD_DAC1, i_io_dir_in,
                      i_io_strobe);
    cmd_dac2 = st_r.selected &&
               is_out(i_io_cmd, CBD_CMD_DAC2, i_io_dir_in,
                      i_io_strobe);
    cmd_adc  = st_r.selected &&
               is_out(i_io_cmd, CBD_CMD_ADC_GO, i_io_dir_in,
                      i_io_strobe);
    rd_window = st_r.selected && i_io_dir_in &&
                (i_io_cmd == CBD_CMD_ADC_READ);
    // the drive enable follows the level; only the strobe clears the flag
    cmd_rd    = rd_window && i_io_strobe;
    // only a fresh rise counts: the converter holds done until restarted
    done_rise = adc_done_s && !st_r.done_prev;
    // differential mode folds the channel onto eight pairs
    chan_in = i_io_data[3:0];
    if (lnk[CBD_LNK_DIFF]) begin
      chan_in[3] = 1'b0;
    end
    // IDLE and BUSY transfers are not taken
    ahb_take = i_hsel && i_hready && (i_htrans == CBD_HTRANS_NONSEQ ||
               i_htrans == 2'h3);
  end

  // ==========================================================================
  // register read mux, unmapped reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    // taken in the address phase: a read sees state before that edge
    if (ofs_hit(i_haddr[7:0], CBD_OFS_LINKS)) begin
      rd_word[3:0] = lnk;
    end else if (ofs_hit(i_haddr[7:0], CBD_OFS_STATUS)) begin
      rd_word[CBD_ST_SELECTED] = st_r.selected;
      rd_word[CBD_ST_SRQ]      = st_r.srq;
      rd_word[CBD_ST_BUSY]     = (st_r.adc_st != CBD_ADC_IDLE);
      rd_word[CBD_ST_CHAN_LSB +: 4] = st_r.chan;
    end else if (ofs_hit(i_haddr[7:0], CBD_OFS_DAC)) begin
      rd_word[15:0] = {st_r.dac2, st_r.dac1};
    end else if (ofs_hit(i_haddr[7:0], CBD_OFS_RESULT)) begin
      rd_word[7:0] = st_r.result;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt         = st_r;
    // go pulses last one cycle unless a write sets them again
    st_nxt.dac1_go = 1'b0;
    st_nxt.dac2_go = 1'b0;
    st_nxt.done_prev = adc_done_s;

    // board select: matching code selects, any other deselects
    if (cmd_sel) begin
      // deselecting leaves the d/a latches driving their ladders
      st_nxt.selected = (i_io_data == P_SELECT_CODE);
    end

    // d/a latches hold until their own command recurs
    if (cmd_dac1) begin
      st_nxt.dac1    = i_io_data;
      st_nxt.dac1_go = 1'b1;
    end
    if (cmd_dac2) begin
      st_nxt.dac2    = i_io_data;
      st_nxt.dac2_go = 1'b1;
    end

    // service request: clears first; completion below wins over a read, a restart in wait wins over completion
    if (cmd_adc || cmd_rd) begin
      st_nxt.srq = 1'b0;
    end

    case (st_r.adc_st)
      CBD_ADC_IDLE: begin
        if (cmd_adc) begin
          st_nxt.chan   = chan_in;
          st_nxt.adc_st = CBD_ADC_START;
        end
      end
      CBD_ADC_START: begin
        // one cycle here makes the start pulse
        st_nxt.adc_st = CBD_ADC_WAIT;
      end
      CBD_ADC_WAIT: begin
        if (done_rise) begin
          // converter output already carries the link's coding
          st_nxt.result = i_adc_data;
          st_nxt.srq    = 1'b1;
          st_nxt.adc_st = CBD_ADC_IDLE;
        end
        if (cmd_adc) begin
          // a new start aborts the pending one and restarts
          st_nxt.chan   = chan_in;
          st_nxt.srq    = 1'b0;
          st_nxt.adc_st = CBD_ADC_START;
        end
      end
      default: begin
        st_nxt.adc_st = CBD_ADC_IDLE;
      end
    endcase

    // bus clear drops selection and any conversion in flight
    if (!i_bus_clear_n) begin
      st_nxt.selected = 1'b0;
      st_nxt.srq      = 1'b0;
      st_nxt.adc_st   = CBD_ADC_IDLE;
    end

    // ahb: write lands in the data phase
    // other offsets are read-only: a write there is dropped, still OKAY
    if (st_r.wr_pend && ofs_hit(st_r.wr_addr, CBD_OFS_LINKS)) begin
      st_nxt.links = i_hwdata[3:0];
    end
    st_nxt.wr_pend = ahb_take && i_hwrite;
    if (ahb_take) begin
      st_nxt.wr_addr = i_haddr[7:0];
      st_nxt.hrdata  = i_hwrite ? CBD_RDATA_RST : rd_word;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // d/a outputs
  always_comb begin
    o_dac1_code         = st_r.dac1;
    o_dac2_code         = st_r.dac2;
    o_dac1_go           = st_r.dac1_go;
    o_dac2_go           = st_r.dac2_go;
    // range bits pick the ladder offset: straight vs offset binary
    o_dac1_bipolar      = lnk[CBD_LNK_DAC1_BIP];
    o_dac2_bipolar      = lnk[CBD_LNK_DAC2_BIP];
  end

  // ==========================================================================
  // a/d outputs
  always_comb begin
    o_adc_bipolar       = lnk[CBD_LNK_ADC_BIP];
    o_adc_differential  = lnk[CBD_LNK_DIFF];
    // start is a one-cycle pulse out of the start state
    o_adc_start         = (st_r.adc_st == CBD_ADC_START);
    o_adc_channel       = st_r.chan;
    o_conversion_done_flag_input = st_r.srq;
  end

  // ==========================================================================
  // processor and register bus outputs
  always_comb begin
    o_io_data           = st_r.result;
    o_io_data_oe        = rd_window;
    // zero wait states, so the slave never stretches a transfer
    o_hreadyout         = 1'b1;
    o_hresp             = 1'b0;
    o_hrdata            = st_r.hrdata;
  end

  // ==========================================================================
  // inputs the slave accepts but never needs
  logic unused_ok;
  assign unused_ok = ^{i_haddr[31:8], i_hsize, i_hwdata[31:4]};

endmodule : cbd_top
`default_nettype wire

// ==== cbd_chk.sv ====
// port assertions for the converter board command decoder
`timescale 1ns/1ns
`default_nettype none
module cbd_chk
  import cbd_pkg::*;
#(
  parameter logic [7:0] P_SELECT_CODE = CBD_SELECT_DEF
) (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_bus_clear_n,
  input wire logic [2:0] i_io_cmd,
  input wire logic       i_io_dir_in,
  input wire logic       i_io_strobe,
  input wire logic [7:0] i_io_data,
  input wire logic       o_io_data_oe,
  input wire logic       o_conversion_done_flag_input,
  input wire logic [7:0] o_dac1_code,
  input wire logic [7:0] o_dac2_code,
  input wire logic       o_dac1_go,
  input wire logic       o_dac2_go,
  input wire logic       o_adc_start,
  input wire logic [3:0] o_adc_channel,
  input wire logic       o_adc_differential,
  input wire logic       i_adc_done
);
  // ==========================================================================
  // helper state
  logic       sel_r;
  logic [3:0] age_r;
  logic [7:0] dat_r;
  wire logic  wr = i_io_strobe && !i_io_dir_in;
  wire logic  flg = o_conversion_done_flag_input;

  always_ff @(posedge i_clk) begin
    dat_r <= i_io_data;
    if (!i_nrst || !i_bus_clear_n) sel_r <= 1'b0;
    else if (wr && i_io_cmd == CBD_CMD_SELECT)
      sel_r <= (i_io_data == P_SELECT_CODE);
    // age of the done level, so a read is judged only once it has settled
    if (!i_nrst || $changed(i_adc_done)) age_r <= 4'h0;
    else if (age_r != 4'hF) age_r <= age_r + 4'h1;
  end

  // ==========================================================================
  // assertions
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  dac1_write_a: assert property (
    sel_r && wr && i_io_cmd == CBD_CMD_DAC1
    |=> o_dac1_go && o_dac1_code == dat_r ##1 !o_dac1_go)
    else $error("dac1 write not taken");
  dac2_write_a: assert property (
    sel_r && wr && i_io_cmd == CBD_CMD_DAC2
    |=> o_dac2_go && o_dac2_code == dat_r ##1 !o_dac2_go)
    else $error("dac2 write not taken");
  dac_hold_a: assert property (
    !o_dac1_go && !o_dac2_go |-> $stable(o_dac1_code) && $stable(o_dac2_code))
    else $error("dac code moved without a write");
  unsel_ignore_a: assert property (
    !sel_r && wr && i_io_cmd inside {3'h3, 3'h4, 3'h5}
    |=> !o_dac1_go && !o_dac2_go && !o_adc_start ##1 !o_adc_start)
    else $error("command acted on while deselected");
  adc_start_a: assert property (
    sel_r && wr && i_io_cmd == CBD_CMD_ADC_GO
    |=> o_adc_start && !flg && o_adc_channel == (o_adc_differential ?
        {1'b0, dat_r[2:0]} : dat_r[3:0]) ##1 !o_adc_start)
    else $error("a/d start wrong");
  read_enable_a: assert property (
    o_io_data_oe == (sel_r && i_io_dir_in && i_io_cmd == CBD_CMD_ADC_READ))
    else $error("read drive enable wrong");
  read_clear_a: assert property (
    sel_r && i_io_strobe && i_io_dir_in && i_io_cmd == CBD_CMD_ADC_READ
    && age_r == 4'hF |=> !flg)
    else $error("read left service request set");
  flag_set_a: assert property (
    $rose(i_adc_done) && i_bus_clear_n |-> ##[1:6] flg)
    else $error("completion not flagged");
  clear_flag_a: assert property (
    !i_bus_clear_n |=> !flg)
    else $error("bus clear left flag set");

  cover property (sel_r && wr && i_io_cmd == CBD_CMD_DAC2);
  cover property (o_io_data_oe && i_io_strobe);
  cover property ($rose(flg));
endmodule : cbd_chk
`default_nettype wire

// ==== cbd_adc_model.sv ====
// behavioural a/d converter answering the decoder's start pulses
`timescale 1ns/1ns
`default_nettype none
module cbd_adc_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_value,
  input  wire logic [7:0] i_delay,
  output logic            o_done,
  output logic      [7:0] o_data
);
  logic [7:0] cnt_r;
  logic       busy_r = 1'b0;
  initial o_done = 1'b0;
  initial o_data = 8'h00;
  initial cnt_r = 8'h00;

  always @(posedge i_clk) begin
    if (i_start) begin
      o_done <= 1'b0;
      // garbage while converting, so a stale result cannot pass
      o_data <= ~i_value;
      cnt_r  <= i_delay;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01) o_data <= i_value;
      if (cnt_r == 8'h00) begin
        o_done <= 1'b1;
        busy_r <= 1'b0;
      end
    end
  end
endmodule : cbd_adc_model
`default_nettype wire

// ==== cbd_top_tb.sv ====
// self-checking bench for the converter board command decoder
`timescale 1ns/1ns
`default_nettype none
module cbd_top_tb;
  import cbd_pkg::*;
  logic        clk, nrst, bclr_n, dir_in, stb, oe, flag, go1, go2;
  logic        bip1, bip2, start, diff, adc_bip, done, hsel, hwrite;
  logic        hready, hresp;
  logic [2:0]  cmd, hsize;
  logic [1:0]  htrans;
  logic [3:0]  chan;
  logic [7:0]  wdat, rdat, dac1, dac2, adat, aval, adly, mres;
  logic [7:0]  mdac[2];
  logic [31:0] haddr, hwdata, hrdata;
  int          err_count = 0;
  int          checked = 0;

  cbd_top #(.P_BIPOLAR_CAPABLE(1'b1),
            .P_SELECT_CODE(CBD_SELECT_DEF)) u_cbd_top (
    .i_clk(clk), .i_nrst(nrst), .i_bus_clear_n(bclr_n), .i_io_cmd(cmd),
    .i_io_dir_in(dir_in), .i_io_strobe(stb), .i_io_data(wdat),
    .o_io_data(rdat), .o_io_data_oe(oe), .o_conversion_done_flag_input(flag),
    .o_dac1_code(dac1), .o_dac2_code(dac2), .o_dac1_go(go1), .o_dac2_go(go2),
    .o_dac1_bipolar(bip1), .o_dac2_bipolar(bip2), .o_adc_start(start),
    .o_adc_channel(chan), .o_adc_differential(diff), .o_adc_bipolar(adc_bip),
    .i_adc_done(done), .i_adc_data(adat), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata));
  cbd_adc_model u_cbd_adc_model (.i_clk(clk), .i_start(start),
    .i_value(aval), .i_delay(adly), .o_done(done), .o_data(adat));

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= CBD_HTRANS_NONSEQ;
    do @(posedge clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (!hready);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask : rd_chk
  // one processor i/o instruction; returns just after the taking edge
  task automatic io(input logic [2:0] c, input logic d, input logic [7:0] x);
    @(posedge clk);
    cmd    <= c;
    dir_in <= d;
    wdat   <= x;
    stb    <= 1'b1;
    if (d) begin
      #1;
      chk(oe, 1'b1);
      chk(rdat, mres);
    end
    @(posedge clk);
    stb <= 1'b0;
    #1;
  endtask : io
  task automatic wait_flag;
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(flag, 1'b1);
  endtask : wait_flag

  // ==========================================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
  initial begin
    logic [31:0] v;
    int k, r, ch;
    {nrst, stb, dir_in, hsel, hwrite, htrans} = '0;
    {bclr_n, cmd, wdat, haddr, hwdata, aval, mres} = {1'b1, 91'h0};
    hsize = 3'h2;
    adly = 8'h04;
    void'($urandom(32'h0D10));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(CBD_OFS_LINKS, 32'h0000_000F);
    rd_chk(CBD_OFS_DAC, 32'h0);
    io(CBD_CMD_DAC1, 1'b0, 8'hA5);
    chk({go1, dac1}, 9'h000);
    io(CBD_CMD_ADC_GO, 1'b0, 8'h01);
    chk(start, 1'b0);
    io(CBD_CMD_SELECT, 1'b0, CBD_SELECT_DEF);
    rd_chk(CBD_OFS_STATUS, 32'h1);
    mdac = '{8'h00, 8'h00};
    for (k = 0; k < 6; k++) begin
      v[7:0] = k == 0 ? 8'h00 : k == 1 ? 8'hFF : k == 2 ? 8'h80 : 8'($urandom);
      io(k[0] ? CBD_CMD_DAC2 : CBD_CMD_DAC1, 1'b0, v[7:0]);
      mdac[k[0]] = v[7:0];
      chk({go2, go1}, k[0] ? 2'b10 : 2'b01);
      chk({dac2, dac1}, {mdac[1], mdac[0]});
    end
    rd_chk(CBD_OFS_DAC, {16'h0, mdac[1], mdac[0]});
    for (k = 0; k < 16; k++) begin
      ahb(1'b1, CBD_OFS_LINKS, k, v);
      #1;
      chk({diff, adc_bip, bip2, bip1}, k[3:0]);
      rd_chk(CBD_OFS_LINKS, k);
    end
    for (k = 0; k < 8; k++) begin
      ahb(1'b1, CBD_OFS_LINKS, {28'h0, k[0], 3'h7}, v);
      ch = $urandom_range(15);
      mres = 8'($urandom);
      aval <= mres;
      adly <= 8'($urandom_range(40, 2));
      // second pass restarts with the flag already set
      for (r = 0; r <= int'(k[1]); r++) begin
        io(CBD_CMD_ADC_GO, 1'b0, 8'(ch));
        chk({start, flag, chan},
            {2'b10, k[0] ? {1'b0, ch[2:0]} : ch[3:0]});
        wait_flag();
      end
      repeat (12) @(posedge clk);
      io(CBD_CMD_ADC_READ, 1'b1, 8'h00);
      chk(flag, 1'b0);
      rd_chk(CBD_OFS_RESULT, {24'h0, mres});
    end
    io(CBD_CMD_SELECT, 1'b0, CBD_SELECT_DEF + 8'h01);
    io(CBD_CMD_DAC1, 1'b0, 8'h5A);
    chk({go1, dac1}, {1'b0, mdac[0]});
    io(CBD_CMD_SELECT, 1'b0, CBD_SELECT_DEF);
    io(CBD_CMD_ADC_GO, 1'b0, 8'h00);
    wait_flag();
    bclr_n <= 1'b0;
    @(posedge clk);
    bclr_n <= 1'b1;
    #1;
    chk(flag, 1'b0);
    io(CBD_CMD_DAC2, 1'b0, 8'h11);
    chk(go2, 1'b0);
    ahb(1'b1, CBD_OFS_STATUS, 32'hFFFF_FFFF, v);
    rd_chk(CBD_OFS_STATUS, 32'h0);
    rd_chk(32'h0000_0010, 32'h0);
    end_sim();
  end
endmodule : cbd_top_tb

bind cbd_top cbd_chk #(.P_SELECT_CODE(P_SELECT_CODE)) u_cbd_chk (
  .i_clk, .i_nrst, .i_bus_clear_n, .i_io_cmd, .i_io_dir_in, .i_io_strobe,
  .i_io_data, .o_io_data_oe, .o_conversion_done_flag_input, .o_dac1_code,
  .o_dac2_code, .o_dac1_go, .o_dac2_go, .o_adc_start, .o_adc_channel,
  .o_adc_differential, .i_adc_done);
`default_nettype wire
